// ==== hw/sct_pair_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Small valid/ready buffer; full and empty follow the true count.
// ------------------------------------------------------------------
module sct_pair_fifo import sct_pkg::*; #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 2
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];  // Entry storage.
   logic [AW-1:0]    wr_reg;           // Write slot.
   logic [AW-1:0]    rd_reg;           // Read slot.
   logic [AW:0]      count_reg;        // Words held.
   logic             push;
   logic             pop;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
         $error("sct_pair_fifo: DEPTH must be a power of two, 2 or more.");
      end
   endgenerate

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_reg[rd_reg];

   // Storage is written without reset; only valid slots are ever read.
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   // Pointers and count move together.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + AW'(1);
         end
         if (pop) begin
            rd_reg <= rd_reg + AW'(1);
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ==== hw/sct_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Two-stage synchroniser for pins arriving from outside ref_clk.
// ------------------------------------------------------------------
module sct_sync2 import sct_pkg::*; #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Asynchronous input and synchronised output.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   // First stage is read by the second stage only.
   logic [WIDTH-1:0] meta_reg;

   generate
      if (WIDTH < 1) begin : g_bad
         $error("sct_sync2: WIDTH must be at least 1.");
      end
   endgenerate

   // Both stages clear on reset and otherwise follow the pin.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== hw/sct_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"
// Summary of operation
// - Input cells fold pins into 18-bit signature.
// - Output shift stages count up each rising edge the buffer accepts.
// - Falling edge latches count onto output pins.
// - Pins sampled on rising test-clock edge.
// - Serial and pin outputs change on falling edge.
// - Controller state advances on rising edge only.
// - Capture-instruction loads fixed pattern 10000001.
// - Instruction shifts in from serial input.
// - Serial output driven from falling edge in shift.
// - Mode high ends shift into first exit.
// - Serial output released in first exit state.
// - Instruction takes effect in update; ones bypass.
// - Bypass stage captures zero leaving capture-data.
// - Update-data loads the selected data register.
// - Select value 111 chooses signature with upcount.
// - Operation runs only run-test instruction in idle.
// - Mixed byte directions stop the combined operation.
module sct_top import sct_pkg::*; #(
   parameter int SIG_W = `SCT_SIG_W,
   parameter int DEPTH = `SCT_FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Serial test link pins.
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   output logic                  tdo,
   output logic                  tdo_oe,
   // Direction controls of the two bytes, active low.
   input  wire logic             byte1_a_to_b_drive_n,
   input  wire logic             byte2_a_to_b_drive_n,
   input  wire logic             byte1_b_to_a_drive_n,
   input  wire logic             byte2_b_to_a_drive_n,
   // Input-mode and output-mode pins of the boundary.
   input  wire logic [SIG_W-1:0] in_pins,
   output logic      [SIG_W-1:0] out_pins,
   // Signature stream toward the user side.
   output logic                  sig_valid,
   input  wire logic             sig_ready,
   output logic      [SIG_W-1:0] sig_data
);
   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   generate
      if (SIG_W != `SCT_SIG_W) begin : g_bad_w
         $error("sct_top: the feedback taps serve an 18-bit signature only.");
      end
   endgenerate

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   localparam int SW = 7 + SIG_W;          // Synchronised pin count.
   localparam int CW = 2 * SIG_W;          // Boundary chain length.
   localparam logic [SIG_W-1:0] TAPS = `SCT_SIG_TAPS;

   logic [SW-1:0]       sync_w;            // All pins after two flops.
   logic                tck_s;             // Synchronised test clock.
   logic                tms_s;             // Synchronised mode select.
   logic                tdi_s;             // Synchronised serial input.
   logic [3:0]          dir_s;             // Synchronised direction pins.
   logic [SIG_W-1:0]    pins_s;            // Synchronised input pins.
   logic                tck_d_reg;         // Previous test clock level.
   logic                tck_rise;          // Test clock rose this cycle.
   logic                tck_fall;          // Test clock fell this cycle.
   sct_tap_state_t      state_reg;         // Controller state.
   sct_tap_state_t      state_next;        // Its next value.
   logic [`SCT_IR_W-1:0] ir_shift_reg;     // Instruction shift stage.
   logic [`SCT_IR_W-1:0] ir_reg;           // Active instruction.
   logic                bypass_reg;        // Single bypass stage.
   logic [`SCT_OP_W-1:0] op_shift_reg;     // Operation select shift stage.
   logic [`SCT_OP_W-1:0] op_reg;           // Active operation select.
   logic [SIG_W-1:0]    sig_reg;           // Input cells: signature.
   logic [SIG_W-1:0]    cnt_reg;           // Output cells: count.
   logic [SIG_W-1:0]    hold_reg;          // Output holding latches.
   logic                dir_ok;            // Both bytes one direction.
   sct_dr_sel_t         dr_sel;            // Selected data register.
   logic                run_active;        // Combined operation live.
   logic                push_valid;        // Signature word offered.
   logic                push_ready;        // Buffer can take a word.

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // One signature step: shift with feedback, then fold in the pins.
   function automatic logic [SIG_W-1:0] psa_step(input logic [SIG_W-1:0] s,
                                                 input logic [SIG_W-1:0] p);
      logic fb;
      fb = ^(s & TAPS);
      return {s[SIG_W-2:0], fb} ^ p;
   endfunction

   // Standard test port state walk.
   function automatic sct_tap_state_t tap_next(input sct_tap_state_t s,
                                               input logic m);
      case (s)
         SCT_TLR:      tap_next = m ? SCT_TLR      : SCT_RTI;
         SCT_RTI:      tap_next = m ? SCT_SEL_DR   : SCT_RTI;
         SCT_SEL_DR:   tap_next = m ? SCT_SEL_IR   : SCT_CAP_DR;
         SCT_CAP_DR:   tap_next = m ? SCT_EXIT1_DR : SCT_SHIFT_DR;
         SCT_SHIFT_DR: tap_next = m ? SCT_EXIT1_DR : SCT_SHIFT_DR;
         SCT_EXIT1_DR: tap_next = m ? SCT_UPD_DR   : SCT_PAUSE_DR;
         SCT_PAUSE_DR: tap_next = m ? SCT_EXIT2_DR : SCT_PAUSE_DR;
         SCT_EXIT2_DR: tap_next = m ? SCT_UPD_DR   : SCT_SHIFT_DR;
         SCT_UPD_DR:   tap_next = m ? SCT_SEL_DR   : SCT_RTI;
         SCT_SEL_IR:   tap_next = m ? SCT_TLR      : SCT_CAP_IR;
         SCT_CAP_IR:   tap_next = m ? SCT_EXIT1_IR : SCT_SHIFT_IR;
         SCT_SHIFT_IR: tap_next = m ? SCT_EXIT1_IR : SCT_SHIFT_IR;
         SCT_EXIT1_IR: tap_next = m ? SCT_UPD_IR   : SCT_PAUSE_IR;
         SCT_PAUSE_IR: tap_next = m ? SCT_EXIT2_IR : SCT_PAUSE_IR;
         SCT_EXIT2_IR: tap_next = m ? SCT_UPD_IR   : SCT_SHIFT_IR;
         SCT_UPD_IR:   tap_next = m ? SCT_SEL_DR   : SCT_RTI;
         default:      tap_next = SCT_TLR;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers and test clock edges
   // ------------------------------------------------------------------
   // All link pins share one synchroniser so their delays match.
   sct_sync2 #(
      .WIDTH (SW)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in ({tck, tms, tdi, byte1_a_to_b_drive_n, byte2_a_to_b_drive_n,
                  byte1_b_to_a_drive_n, byte2_b_to_a_drive_n, in_pins}),
      .sync_out (sync_w)
   );

   assign tck_s  = sync_w[SW-1];
   assign tms_s  = sync_w[SW-2];
   assign tdi_s  = sync_w[SW-3];
   assign dir_s  = sync_w[SW-4:SW-7];
   assign pins_s = sync_w[SIG_W-1:0];

   // The test clock runs at 200 ns, eight ref_clk periods, so each
   // level is seen at least twice and no edge can be missed.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tck_d_reg <= 1'b0;
      end else begin
         tck_d_reg <= tck_s;
      end
   end

   assign tck_rise = tck_s && !tck_d_reg;
   assign tck_fall = !tck_s && tck_d_reg;

   // ------------------------------------------------------------------
   // Controller state machine
   // ------------------------------------------------------------------
   // A high mode select in a shift state moves to the first exit.
   assign state_next = tap_next(state_reg, tms_s);

   // The state only moves on a rising test clock edge.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= SCT_TLR;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------------
   // Both bytes must move data, and the same way, for any test run.
   assign dir_ok = (dir_s[3] != dir_s[1]) && (dir_s[2] != dir_s[0])
                && (dir_s[3] == dir_s[2]) && (dir_s[1] == dir_s[0]);

   // Unknown opcodes and the all-ones opcode pick the bypass stage.
   always_comb begin
      case (ir_reg)
         `SCT_IR_OP_SCAN:    dr_sel = SCT_DR_OP;
         `SCT_IR_CHAIN_READ: dr_sel = SCT_DR_CHAIN;
         default:            dr_sel = SCT_DR_BYPASS;
      endcase
   end

   // The combined operation needs the run instruction, idle, select
   // value 111 and consistent directions; otherwise nothing moves.
   assign run_active = (ir_reg == `SCT_IR_RUN_TEST) && (state_reg == SCT_RTI)
                    && (op_reg == `SCT_OP_SIG_COUNT) && dir_ok;

   // ------------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------------
   // Shift stage: fixed capture pattern, then serial fill from the link.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ir_shift_reg <= `SCT_IR_CAPTURE;
      end else if (tck_rise) begin
         if (state_reg == SCT_CAP_IR) begin
            ir_shift_reg <= `SCT_IR_CAPTURE;
         end else if (state_reg == SCT_SHIFT_IR) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[`SCT_IR_W-1:1]};
         end
      end
   end

   // Active instruction changes on the falling edge in update; the
   // reset state forces bypass so a stray opcode never survives.
   always_ff @(posedge ref_clk) begin
      if (rst || state_reg == SCT_TLR) begin
         ir_reg <= `SCT_IR_BYPASS;
      end else if (tck_fall && state_reg == SCT_UPD_IR) begin
         ir_reg <= ir_shift_reg;
      end
   end

   // ------------------------------------------------------------------
   // Bypass stage
   // ------------------------------------------------------------------
   // One flop between serial in and out: a bit appears one shift later.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bypass_reg <= 1'b0;
      end else if (tck_rise && dr_sel == SCT_DR_BYPASS) begin
         if (state_reg == SCT_CAP_DR) begin
            bypass_reg <= 1'b0;
         end else if (state_reg == SCT_SHIFT_DR) begin
            bypass_reg <= tdi_s;
         end
      end
   end

   // ------------------------------------------------------------------
   // Operation select register
   // ------------------------------------------------------------------
   // The shift stage keeps its value through capture.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         op_shift_reg <= `SCT_OP_RESET;
      end else if (tck_rise && dr_sel == SCT_DR_OP && state_reg == SCT_SHIFT_DR) begin
         op_shift_reg <= {tdi_s, op_shift_reg[`SCT_OP_W-1:1]};
      end
   end

   // The select value is taken on the falling edge in update.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         op_reg <= `SCT_OP_RESET;
      end else if (tck_fall && dr_sel == SCT_DR_OP && state_reg == SCT_UPD_DR) begin
         op_reg <= op_shift_reg;
      end
   end

   // ------------------------------------------------------------------
   // Boundary chain: signature cells and count cells
   // ------------------------------------------------------------------
   // The buffer takes every signature word; when it is full the step is
   // held back, trading strict edge pacing for no lost word.
   assign push_valid = tck_rise && run_active;

   // The chain shifts as one 36-bit register, count cells nearest the
   // serial input, so the controller can seed both halves.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sig_reg <= '0;
         cnt_reg <= '0;
      end else if (push_valid && push_ready) begin
         sig_reg <= psa_step(sig_reg, pins_s);
         cnt_reg <= cnt_reg + SIG_W'(1);
      end else if (tck_rise && dr_sel == SCT_DR_CHAIN && state_reg == SCT_SHIFT_DR) begin
         {cnt_reg, sig_reg} <= {tdi_s, cnt_reg, sig_reg[SIG_W-1:1]};
      end
   end

   // Holding latches drive the output pins and move on falling edges
   // only: each run step shows the new count, each update the scanned.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_reg <= '0;
      end else if (tck_fall && run_active) begin
         hold_reg <= cnt_reg;
      end else if (tck_fall && dr_sel == SCT_DR_CHAIN && state_reg == SCT_UPD_DR) begin
         hold_reg <= cnt_reg;
      end
   end

   assign out_pins = hold_reg;

   // ------------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------------
   // Driven from the first falling edge in a shift state, released on
   // the falling edge in the first exit; the value is the low bit.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe <= (state_reg == SCT_SHIFT_IR) || (state_reg == SCT_SHIFT_DR);
         if (state_reg == SCT_SHIFT_IR) begin
            tdo <= ir_shift_reg[0];
         end else if (state_reg == SCT_SHIFT_DR) begin
            case (dr_sel)
               SCT_DR_OP:    tdo <= op_shift_reg[0];
               SCT_DR_CHAIN: tdo <= sig_reg[0];
               default:      tdo <= bypass_reg;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Signature stream buffer
   // ------------------------------------------------------------------
   sct_pair_fifo #(
      .WIDTH (SIG_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (psa_step(sig_reg, pins_s)),
      .out_valid (sig_valid),
      .out_ready (sig_ready),
      .out_data  (sig_data)
   );

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence in_shift_fall;
      tck_fall && (state_reg == SCT_SHIFT_IR || state_reg == SCT_SHIFT_DR);
   endsequence

   sequence exit1_fall;
      tck_fall && (state_reg == SCT_EXIT1_IR || state_reg == SCT_EXIT1_DR);
   endsequence

   sig_fold_a: assert property (push_valid && push_ready |=>
      sig_reg == psa_step($past(sig_reg), $past(pins_s)))
      else $error("Signature step did not fold the pins.");

   count_step_a: assert property (push_valid && push_ready |=>
      cnt_reg == $past(cnt_reg) + SIG_W'(1))
      else $error("Count cells did not advance by one.");

   latch_count_a: assert property (tck_fall && run_active |=>
      out_pins == $past(cnt_reg))
      else $error("Output pins did not take the count.");

   pins_on_fall_a: assert property (!tck_fall |=> $stable(out_pins))
      else $error("Output pins changed away from a falling edge.");

   tap_on_rise_a: assert property (!tck_rise |=> $stable(state_reg))
      else $error("Controller moved without a rising edge.");

   ir_capture_a: assert property (tck_rise && state_reg == SCT_CAP_IR |=>
      ir_shift_reg == `SCT_IR_CAPTURE)
      else $error("Capture pattern not loaded.");

   ir_shift_a: assert property (tck_rise && state_reg == SCT_SHIFT_IR |=>
      ir_shift_reg == {$past(tdi_s), $past(ir_shift_reg[`SCT_IR_W-1:1])})
      else $error("Instruction shift stage did not shift.");

   tdo_drive_a: assert property (in_shift_fall |=> tdo_oe)
      else $error("Serial output not driven in shift.");

   tdo_release_a: assert property (exit1_fall |=> !tdo_oe ##1 !tdo_oe)
      else $error("Serial output not released in first exit.");

   ir_update_a: assert property (tck_fall && state_reg == SCT_UPD_IR |=>
      ir_reg == $past(ir_shift_reg))
      else $error("Instruction did not take effect in update.");

   bypass_zero_a: assert property (tck_rise && state_reg == SCT_CAP_DR
      && dr_sel == SCT_DR_BYPASS |=> !bypass_reg)
      else $error("Bypass stage did not capture zero.");

   mixed_dir_a: assert property (!dir_ok |-> !run_active)
      else $error("Operation ran with mixed byte directions.");
endmodule
`default_nettype wire

// ==== inc/sct_params.svh ====
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
// ------------------------------------------------------------------
// Instruction register layout and opcodes
// ------------------------------------------------------------------
`define SCT_IR_W          8
`define SCT_IR_CAPTURE    8'h81
`define SCT_IR_BYPASS     8'hFF
`define SCT_IR_RUN_TEST   8'h09
`define SCT_IR_OP_SCAN    8'h0A
`define SCT_IR_CHAIN_READ 8'h02
// ------------------------------------------------------------------
// Test operation select register and signature word
// ------------------------------------------------------------------
`define SCT_OP_W          3
`define SCT_OP_RESET      3'h0
`define SCT_OP_SIG_COUNT  3'h7
`define SCT_SIG_W         18
`define SCT_SIG_TAPS      18'h20400
`define SCT_FIFO_DEPTH    2
`endif

// ==== inc/sct_pkg.sv ====
package sct_pkg;
   // Test port controller states.
   typedef enum logic [3:0] {
      SCT_TLR, SCT_RTI, SCT_SEL_DR, SCT_CAP_DR, SCT_SHIFT_DR, SCT_EXIT1_DR,
      SCT_PAUSE_DR, SCT_EXIT2_DR, SCT_UPD_DR, SCT_SEL_IR, SCT_CAP_IR,
      SCT_SHIFT_IR, SCT_EXIT1_IR, SCT_PAUSE_IR, SCT_EXIT2_IR, SCT_UPD_IR
   } sct_tap_state_t;
   // Data register placed between the serial input and output.
   typedef enum logic [1:0] {SCT_DR_BYPASS, SCT_DR_OP, SCT_DR_CHAIN} sct_dr_sel_t;
endpackage

// ==== sim/sct_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Test controller model of the far side of the serial link.
// ------------------------------------------------------------------
module sct_ctl_model (
   // Bench clock and resolved serial output line.
   input  wire logic ref_clk,
   input  wire logic tdo_line,
   input  wire logic tdo_oe,
   // Link pins toward the block.
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   // Mode high at start keeps the port in its reset state.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One 200 ns period: fall with new mode and data, rise, then sample.
   task automatic step(input logic m, input logic d, output logic q, output logic oe);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge ref_clk);
      tck <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 q = tdo_line;
      oe = tdo_oe;
      @(posedge ref_clk);
   endtask
   // Scan from idle back to idle; bit i of din enters at shift step i.
   task automatic scan(input logic ir, input logic [35:0] din, input int n,
                       output logic [35:0] dout, output logic ok);
      logic q;
      logic oe;
      dout = 36'h0;
      ok = 1'b1;
      step(1'b1, 1'b0, q, oe);
      if (ir) begin
         step(1'b1, 1'b0, q, oe);
      end
      step(1'b0, 1'b0, q, oe);
      step(1'b0, 1'b0, q, oe);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q, oe);
         dout[i] = q;
         ok = ok & oe;
      end
      step(1'b1, 1'b0, q, oe);
      ok = ok & ~oe;
      step(1'b0, 1'b0, q, oe);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import sct_pkg::*; ;
   // Bench signals; the serial line is pulled high when released.
   logic ref_clk, rst, sig_ready, b1ab_n, b2ab_n, b1ba_n, b2ba_n;
   logic tdo, tdo_oe, sig_valid, q, oe, ok;
   wire logic tck, tms, tdi;
   wire logic tdo_line = tdo_oe ? tdo : 1'b1;
   logic [17:0] in_pins, out_pins, sig_data, w1, w2;
   logic [35:0] dout;
   int n_errors = 0;
   int n_tests = 0;
   sct_ctl_model ctl (.ref_clk(ref_clk), .tdo_line(tdo_line), .tdo_oe(tdo_oe),
                      .tck(tck), .tms(tms), .tdi(tdi));
   sct_top #(.SIG_W(18), .DEPTH(2)) DUT (.ref_clk(ref_clk), .rst(rst), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .byte1_a_to_b_drive_n(b1ab_n),
      .byte2_a_to_b_drive_n(b2ab_n), .byte1_b_to_a_drive_n(b1ba_n),
      .byte2_b_to_a_drive_n(b2ba_n), .in_pins(in_pins), .out_pins(out_pins),
      .sig_valid(sig_valid), .sig_ready(sig_ready), .sig_data(sig_data));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Reference signature step, written out independently of the block.
   function automatic logic [17:0] parallel_signature(input logic [17:0] s, input logic [17:0] p);
      return {s[16:0], ^(s & 18'h20400)} ^ p;
   endfunction
   // Capture pattern, enable window, then bypass delay of one stage.
   task automatic test_ir_bypass();
      ctl.scan(1'b1, 36'hFF, 8, dout, ok);
      chk(dout, 36'h81);
      chk({35'h0, ok}, 36'h1);
      ctl.scan(1'b0, 36'h5, 3, dout, ok);
      chk(dout, 36'h2);
      $display("test ir_bypass done");
   endtask
   // Take one stream word after it has stood through a stall.
   task automatic pop(input logic [17:0] w);
      chk({17'h0, sig_valid, sig_data}, {18'h1, w});
      @(posedge ref_clk) sig_ready <= 1'b1;
      @(posedge ref_clk) sig_ready <= 1'b0;
      #1;
   endtask
   // Seeded run with the consumer stalled: two words kept, later steps held.
   task automatic test_sig_count();
      ctl.scan(1'b1, 36'h0A, 8, dout, ok);
      ctl.scan(1'b0, 36'h7, 3, dout, ok);
      ctl.scan(1'b1, 36'h02, 8, dout, ok);
      // Seed: count half 10h, signature half 5h.
      ctl.scan(1'b0, 36'h000400005, 36, dout, ok);
      chk({18'h0, out_pins}, 36'h10);
      ctl.scan(1'b1, 36'h09, 8, dout, ok);
      repeat (5) ctl.step(1'b0, 1'b0, q, oe);
      chk({18'h0, out_pins}, 36'h12);
      w1 = parallel_signature(18'h5, in_pins);
      w2 = parallel_signature(w1, in_pins);
      pop(w1);
      pop(w2);
      chk({35'h0, sig_valid}, 36'h0);
      $display("test sig_count done");
   endtask
   // Byte two driving both ways breaks the direction pairing.
   task automatic test_mixed_dirs();
      @(posedge ref_clk) b2ba_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      repeat (3) ctl.step(1'b0, 1'b0, q, oe);
      chk({17'h0, sig_valid, out_pins}, 36'h12);
      $display("test mixed_dirs done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Whole run takes about 25 us; a hang is cut at 100 us.
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      sig_ready = 1'b0;
      {b1ab_n, b2ab_n, b1ba_n, b2ba_n} = 4'h3;
      in_pins = 18'h2A5C3;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ctl.step(1'b0, 1'b0, q, oe);
      test_ir_bypass();
      test_sig_count();
      test_mixed_dirs();
      report_and_stop();
   end
endmodule
`default_nettype wire
